//--- lrh_node.sv
// Ring node: controller, talker and listener roles with loop handshake.
// Assumes frames arrive already decoded and bit-encoding is done elsewhere.
// How it works
// [R1] Only an active controller node may place command frames on the ring.
// [R2] The talker sends data only after it has been told to send by the controller.
// [R3] The listener stays inactive and ignores data until a listen command enables it.
// [R4] The controller keeps at most one active talker; several listeners may be enabled.
// [R5] The system controller is active at power-up and only one controller is active.
// [R6] Without a controller a node works in fixed talk-only or listen-only mode; talk-only here stalls after one frame, its return never taken.
// [R7] Node addressing supports either 31 or 961 nodes depending on the scheme.
// [R8] Data comes only from the active talker, goes only to listeners, and changes no state.
// [R9] A source waits for its frame to return before sending the next one.
// [R10] Most frames are held until the node is ready, throttling sources to the slowest.
// [R11] A returned frame is compared with the sent one; a mismatch is an error.
// [R12] Commands are forwarded at once while a copy is kept for interpretation.
// [R13] The ready-for-command frame follows each command and is held until ready.
// [R14] Each frame is eleven bits with the leading bit as sync.
// [R15] A talker replaces the send-data ready frame with its first data frame.
// [R16] Reset leaves talker and listener inactive and the controller inactive unless system.
`timescale 1ns/10ps
module lrh_node
  import lrh_pkg::*;
#(
  parameter logic [ADDR_BITS-1:0] MY_ADDR = 10'h001
)(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // Configuration pins
  input  wire logic                  sys_ctrl_pin,
  input  wire logic                  talk_only_pin,
  input  wire logic                  listen_only_pin,
  input  wire logic                  ext_addr_pin,
  // Incoming ring frame
  input  wire logic                  in_valid,
  input  wire logic [FRAME_BITS-1:0] in_frame,
  output logic                       in_ready,
  // Outgoing ring frame
  output logic                       out_valid,
  output logic [FRAME_BITS-1:0]      out_frame,
  input  wire logic                  out_ready,
  // Local user side
  input  wire logic                  user_ready,
  input  wire logic                  user_cmd_valid,
  input  wire logic [7:0]            user_cmd,
  input  wire logic                  user_tx_valid,
  input  wire logic [7:0]            user_tx_data,
  input  wire logic                  user_tx_last,
  output logic                       user_tx_ready,
  output logic                       user_rx_valid,
  output logic [7:0]                 user_rx_data,
  output logic                       talker_active,
  output logic                       listener_active,
  output logic                       ctrl_active,
  output logic                       loop_error
);
  // Pin synchronisers for straps
  logic [3:0] pin_s1, pin_s2;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= {sys_ctrl_pin, talk_only_pin, listen_only_pin, ext_addr_pin};
      pin_s2 <= pin_s1;
    end
  end
  wire sys_ctrl    = pin_s2[3];
  wire talk_only   = pin_s2[2];
  wire listen_only = pin_s2[1];
  wire ext_addr    = pin_s2[0];

  // Frame decode
  wire [2:0] in_cls  = in_frame[CLASS_MSB:CLASS_LSB];
  wire [7:0] in_pay  = in_frame[PAYLOAD_BITS-1:0];
  wire       is_sync = in_frame[SYNC_POS];                    // [R14]
  wire       is_cmd  = is_sync && in_cls == CLS_CMD;
  wire       is_rdy  = is_sync && in_cls == CLS_READY;
  wire       is_data = !is_sync && in_cls == CLS_DATA;
  wire [4:0] cmd_adr = in_pay[4:0];
  // Extended scheme: high part stored from a command with payload bits 7:5 all set, low part from this command's address field
  logic [4:0] ext_hi;
  wire [ADDR_BITS-1:0] full_adr = ext_addr ? {ext_hi, cmd_adr}
                                           : {5'h00, cmd_adr};     // [R7]
  wire addr_ok  = cmd_adr != ADDR_RESET;
  wire addr_hit = addr_ok && full_adr == MY_ADDR;
  wire is_lad   = is_cmd && (in_pay & CMD_ADDR_MASK) == CMD_LISTEN_BASE;
  wire is_tad   = is_cmd && (in_pay & CMD_ADDR_MASK) == CMD_TALK_BASE;
  wire is_unl   = is_cmd && in_pay == CMD_UNLISTEN;
  wire is_unt   = is_cmd && in_pay == CMD_UNTALK;
  wire is_sda   = is_rdy && in_pay == RDY_SEND_DATA;
  wire is_rfc   = is_rdy && in_pay == RDY_FOR_CMD;
  wire is_eot   = is_rdy && in_pay == RDY_END_TX;

  // Role state
  logic talk_addr, sending, cmd_pending;
  logic src_busy, src_done, src_err;
  // Frames held at this node wait for local readiness; commands do not
  wire hold_ok  = user_ready;                                   // [R10] [R13]
  // Loading needs an empty output stage and an idle source; waiting for out_ready here would deadlock
  wire fwd_ok   = !out_valid && !src_busy;
  wire own_src  = sending || ctrl_active;
  wire consume  = in_valid && own_src;
  wire pass_now = in_valid && !own_src && (is_cmd || hold_ok);  // [R12]
  assign in_ready = consume || (pass_now && fwd_ok);

  // Source selection feeding the source handshake
  lrh_ring_if src_req ();
  lrh_ring_if ring_out ();
  wire  ctrl_send = ctrl_active && user_cmd_valid;             // [R1]
  wire  data_send = (sending || talk_only) && user_tx_valid;   // [R2] [R6]
  assign src_req.valid = ctrl_send || data_send;
  assign src_req.frame = ctrl_send ? lrh_frame(CLS_CMD, user_cmd)
                                   : lrh_frame(CLS_DATA, user_tx_data);
  wire src_take = src_req.valid && src_req.ready;
  lrh_source u_src (
    .clock     (clock),
    .rst_n     (rst_n),
    .req       (src_req),
    .ring      (ring_out),
    .ret_valid (in_valid && own_src),
    .ret_frame (in_frame),
    .busy      (src_busy),
    .done      (src_done),
    .err       (src_err)
  );
  assign ring_out.ready = !(pass_now && fwd_ok) && !out_valid;

  logic last_pend;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      talker_active   <= 1'b0;                                 // [R16]
      listener_active <= 1'b0;
      ctrl_active     <= 1'b0;
      talk_addr       <= 1'b0;
      sending         <= 1'b0;
      cmd_pending     <= 1'b0;
      last_pend       <= 1'b0;
      ext_hi          <= '0;
      user_tx_ready   <= 1'b0;
      loop_error      <= 1'b0;
    end else begin
      ctrl_active <= sys_ctrl && !talk_only && !listen_only;   // [R5] [R16]
      if (in_valid && in_ready && !own_src) begin
        if (is_unl) listener_active <= 1'b0;
        if (is_lad && addr_hit) listener_active <= 1'b1;       // [R3] [R4]
        if (is_tad) talk_addr <= addr_hit;                     // [R4]
        if (is_unt) talk_addr <= 1'b0;
        if (is_cmd && in_pay[7:5] == 3'h7) ext_hi <= in_pay[4:0];
      end
      if (in_valid && is_sda && talk_addr && !own_src) sending <= 1'b1;   // [R15]
      talker_active <= talk_addr || talk_only;
      if (src_take && data_send) last_pend <= user_tx_last;
      if (src_done && sending && last_pend) begin
        sending   <= 1'b0;
        last_pend <= 1'b0;
      end
      cmd_pending   <= ctrl_send && src_take ? 1'b1 : (src_done ? 1'b0 : cmd_pending);
      user_tx_ready <= data_send && src_take;
      if (src_done) loop_error <= src_err;                     // [R11]
    end
  end

  // Output register: passed frame or own sourced frame; SDA is swallowed at an addressed talker
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_valid     <= 1'b0;
      out_frame     <= '0;
      user_rx_valid <= 1'b0;
      user_rx_data  <= '0;
    end else begin
      if (out_valid && out_ready) out_valid <= 1'b0;
      if (pass_now && fwd_ok && !out_valid && !(is_sda && talk_addr)) begin
        out_valid <= 1'b1;
        out_frame <= in_frame;
      end else if (ring_out.valid && ring_out.ready) begin
        out_valid <= 1'b1;
        out_frame <= ring_out.frame;
      end
      // Data reaches the user only on an enabled listener or in listen-only mode
      user_rx_valid <= pass_now && fwd_ok && is_data
                       && (listener_active || listen_only);    // [R8] [R3] [R6]
      user_rx_data  <= in_pay;
    end
  end
endmodule : lrh_node

//--- lrh_node_checker.sv
// Port-level assertions for the ring node.
// Assumes one clock domain with an async active-low reset.
`timescale 1ns/10ps
module lrh_node_checker
  import lrh_pkg::*;
(
  // Clock and reset
  input wire logic                  clock,
  input wire logic                  rst_n,
  // Ring and user side
  input wire logic                  in_valid,
  input wire logic [FRAME_BITS-1:0] in_frame,
  input wire logic                  in_ready,
  input wire logic                  out_valid,
  input wire logic [FRAME_BITS-1:0] out_frame,
  input wire logic                  out_ready,
  input wire logic                  user_ready,
  input wire logic                  user_rx_valid,
  // Role flags
  input wire logic                  talker_active,
  input wire logic                  listener_active,
  input wire logic                  ctrl_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic       tk;
  logic [2:0] ic;
  logic [2:0] oc;
  assign tk = in_valid && in_ready;
  assign ic = in_frame[CLASS_MSB:CLASS_LSB];
  assign oc = out_frame[CLASS_MSB:CLASS_LSB];
  sequence s_cmd_in;
    tk && ic == CLS_CMD && !ctrl_active;
  endsequence
  sequence s_fwd;
    out_valid && out_frame == $past(in_frame);
  endsequence
  AST_RST_IDLE: assert property ($rose(rst_n) |-> !talker_active && !listener_active)
    else $error("role flag set after reset");
  AST_CMD_SRC: assert property ($rose(out_valid) && oc == CLS_CMD |-> ctrl_active || $past(tk))
    else $error("command sourced by non-controller");
  AST_DATA_SRC: assert property ($rose(out_valid) && oc == CLS_DATA |-> talker_active || $past(tk))
    else $error("data sourced by inactive talker");
  AST_RX_LSN: assert property (user_rx_valid |-> listener_active || $past(listener_active))
    else $error("data delivered while not listening");
  AST_OUT_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_frame))
    else $error("output frame dropped before ready");
  AST_HOLD_RDY: assert property (in_valid && ic != CLS_CMD && !user_ready |-> !in_ready)
    else $error("frame accepted while node not ready");
  AST_CMD_FWD: assert property (s_cmd_in |=> s_fwd)
    else $error("command not forwarded at once");
  AST_SDA_SWAP: assert property (tk && in_frame == {CLS_READY, RDY_SEND_DATA} && talker_active
    |=> (!(out_valid && out_frame == {CLS_READY, RDY_SEND_DATA}))[*3])
    else $error("send-data frame passed on by talker");
  AST_DATA_KEEP: assert property (tk && ic == CLS_DATA |=> $stable(talker_active) && $stable(listener_active))
    else $error("data frame changed role state");
endmodule : lrh_node_checker
bind lrh_node lrh_node_checker u_chk (.clock, .rst_n, .in_valid, .in_frame, .in_ready,
  .out_valid, .out_frame, .out_ready, .user_ready, .user_rx_valid, .talker_active,
  .listener_active, .ctrl_active);

//--- lrh_node_test.sv
// Self-checking bench for the ring node roles and loop handshake.
// Assumes the ring model stands for every other node of the loop.
`timescale 1ns/10ps
module lrh_node_test;
  import lrh_pkg::*;
  logic clock, rst_n, sys_ctrl_pin, talk_only_pin, listen_only_pin, ext_addr_pin;
  logic in_valid, in_ready, out_valid, out_ready, user_ready, user_cmd_valid, user_tx_valid;
  logic user_tx_last, user_tx_ready, user_rx_valid, talker_active, listener_active;
  logic ctrl_active, loop_error, bv, loop_en, flip;
  logic [1:0] slow;
  logic [7:0] user_cmd, user_tx_data, user_rx_data, rx_last;
  logic [FRAME_BITS-1:0] in_frame, out_frame, bf;
  int n_mismatch = 0, num_checks = 0, rx_cnt = 0;
  lrh_node dut (.clock, .rst_n, .sys_ctrl_pin, .talk_only_pin, .listen_only_pin,
    .ext_addr_pin, .in_valid, .in_frame, .in_ready, .out_valid, .out_frame, .out_ready,
    .user_ready, .user_cmd_valid, .user_cmd, .user_tx_valid, .user_tx_data, .user_tx_last,
    .user_tx_ready, .user_rx_valid, .user_rx_data, .talker_active, .listener_active,
    .ctrl_active, .loop_error);
  lrh_ring_model ring (.clock, .rst_n, .out_valid, .out_frame, .out_ready, .in_valid,
    .in_frame, .in_ready, .bv, .bf, .loop_en, .flip, .slow);
  always #25 clock = ~clock;
  always @(posedge clock) begin
    if (user_rx_valid === 1'b1) begin
      rx_cnt++;
      rx_last = user_rx_data;
    end
  end
  task automatic chk(input string nm, input logic [FRAME_BITS-1:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic put(input logic [FRAME_BITS-1:0] f);
    int i;
    @(negedge clock);
    bv = 1'b1;
    bf = f;
    // Let the combinational ready settle before looking at it
    #1;
    for (i = 0; i < 40 && in_ready !== 1'b1; i++) @(negedge clock);
    chk("in_ready", in_ready, 1'b1);
    @(negedge clock);
    bv = 1'b0;
  endtask : put
  task automatic get(input logic [FRAME_BITS-1:0] exp);
    int i;
    for (i = 0; i < 40 && !(out_valid === 1'b1 && out_ready === 1'b1); i++) @(negedge clock);
    chk("out_frame", out_frame, exp);
    @(negedge clock);
  endtask : get
  task automatic t_idle;
    chk("roles", {talker_active, listener_active, ctrl_active}, 3'h0);
    put({CLS_DATA, 8'h3c});
    get({CLS_DATA, 8'h3c});
    chk("rx_cnt", rx_cnt, 0);
  endtask : t_idle
  task automatic t_talk;
    slow = 2'h2;
    put({CLS_CMD, CMD_TALK_BASE | 8'h01});
    get({CLS_CMD, CMD_TALK_BASE | 8'h01});
    chk("talker", talker_active, 1'b1);
    user_ready = 1'b0;
    bv = 1'b1;
    bf = {CLS_READY, RDY_FOR_CMD};
    repeat (5) @(negedge clock);
    chk("rfc_held", in_ready, 1'b0);
    bv = 1'b0;
    user_ready = 1'b1;
    put({CLS_READY, RDY_FOR_CMD});
    get({CLS_READY, RDY_FOR_CMD});
  endtask : t_talk
  task automatic t_source;
    loop_en = 1'b1;
    user_tx_valid = 1'b1;
    user_tx_data = 8'ha5;
    put({CLS_READY, RDY_SEND_DATA});
    get({CLS_DATA, 8'ha5});
    user_tx_valid = 1'b0;
    repeat (3) @(negedge clock);
    chk("loop_error", loop_error, 1'b0);
    // Corrupt the next return so the compare must flag it
    flip = 1'b1;
    user_tx_data = 8'h5a;
    // Last byte: the talker must stop sourcing once it returns
    user_tx_last = 1'b1;
    user_tx_valid = 1'b1;
    get({CLS_DATA, 8'h5a});
    user_tx_valid = 1'b0;
    user_tx_last = 1'b0;
    repeat (3) @(negedge clock);
    chk("loop_error", loop_error, 1'b1);
    {flip, loop_en} = 2'h0;
    put({CLS_CMD, CMD_UNTALK});
    get({CLS_CMD, CMD_UNTALK});
    chk("talker", talker_active, 1'b0);
  endtask : t_source
  task automatic t_listen;
    put({CLS_CMD, CMD_LISTEN_BASE | 8'h01});
    get({CLS_CMD, CMD_LISTEN_BASE | 8'h01});
    chk("listener", listener_active, 1'b1);
    put({CLS_DATA, 8'hc3});
    get({CLS_DATA, 8'hc3});
    chk("rx", {rx_cnt[2:0], rx_last}, {3'h1, 8'hc3});
  endtask : t_listen
  task automatic t_ctrl;
    sys_ctrl_pin = 1'b1;
    repeat (4) @(negedge clock);
    chk("ctrl", ctrl_active, 1'b1);
    loop_en = 1'b1;
    user_cmd = CMD_UNLISTEN;
    user_cmd_valid = 1'b1;
    get({CLS_CMD, CMD_UNLISTEN});
    user_cmd_valid = 1'b0;
    repeat (4) @(negedge clock);
  endtask : t_ctrl
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    {clock, rst_n, sys_ctrl_pin, talk_only_pin, listen_only_pin, ext_addr_pin} = 6'h00;
    {user_cmd_valid, user_tx_valid, user_tx_last, bv, loop_en, flip} = 6'h00;
    {user_ready, slow, user_cmd, user_tx_data, bf} = {1'b1, 29'h0000_0000};
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    t_idle();
    t_talk();
    t_source();
    t_listen();
    t_ctrl();
    print_verdict();
  end
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
endmodule : lrh_node_test

//--- lrh_pkg.sv
// Shared constants and types for the ring node role and handshake logic.
// Assumes an 11-bit frame: 3 control bits (sync first) and 8 data bits.
package lrh_pkg;
  localparam int unsigned FRAME_BITS     = 11;
  localparam int unsigned PAYLOAD_BITS   = 8;
  localparam int unsigned SYNC_POS       = 10;
  localparam int unsigned CLASS_MSB      = 10;
  localparam int unsigned CLASS_LSB      = 8;
  localparam int unsigned ADDR_BITS      = 10;
  localparam int unsigned MAX_NODES_BASIC = 31;
  localparam int unsigned MAX_NODES_EXT   = 961;
  // Control bit classes (sync bit leading)
  localparam logic [2:0] CLS_DATA    = 3'h0;
  localparam logic [2:0] CLS_CMD     = 3'h4;
  localparam logic [2:0] CLS_READY   = 3'h5;
  // Command payloads
  localparam logic [7:0] CMD_UNLISTEN   = 8'h3f;
  localparam logic [7:0] CMD_UNTALK     = 8'h5f;
  localparam logic [7:0] CMD_LISTEN_BASE = 8'h20;
  localparam logic [7:0] CMD_TALK_BASE  = 8'h40;
  localparam logic [7:0] CMD_ADDR_MASK  = 8'he0;
  localparam logic [7:0] CMD_TAKE_CTRL  = 8'h64;
  // Ready payloads
  localparam logic [7:0] RDY_FOR_CMD    = 8'h00;
  localparam logic [7:0] RDY_SEND_DATA  = 8'h60;
  localparam logic [7:0] RDY_END_TX     = 8'h40;
  localparam logic [4:0] ADDR_RESET     = 5'h1f;

  typedef enum logic [1:0] {LRH_SRC_IDLE, LRH_SRC_WAIT} lrh_src_state_t;

  function automatic logic [FRAME_BITS-1:0] lrh_frame(input logic [2:0] cls,
                                                      input logic [7:0] pay);
    lrh_frame = {cls, pay};
  endfunction : lrh_frame
endpackage : lrh_pkg

//--- lrh_ring_if.sv
// Carries one frame with a valid/ready handshake between ring stages.
// Assumes producer and consumer share the single clock.
`timescale 1ns/10ps
interface lrh_ring_if;
  logic [10:0] frame;
  logic        valid;
  logic        ready;
  modport src (output frame, output valid, input ready);
  modport dst (input frame, input valid, output ready);
endinterface : lrh_ring_if

//--- lrh_ring_model.sv
// Rest of the ring: takes node output, loops the node's own frames back.
// Assumes the bench injects frames only while no loopback is pending.
`timescale 1ns/10ps
module lrh_ring_model
  import lrh_pkg::*;
(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // Node output side
  input  wire logic                  out_valid,
  input  wire logic [FRAME_BITS-1:0] out_frame,
  output logic                       out_ready,
  // Node input side
  output logic                       in_valid,
  output logic [FRAME_BITS-1:0]      in_frame,
  input  wire logic                  in_ready,
  // Bench control
  input  wire logic                  bv,
  input  wire logic [FRAME_BITS-1:0] bf,
  input  wire logic                  loop_en,
  input  wire logic                  flip,
  input  wire logic [1:0]            slow
);
  logic [1:0]            wt;
  logic                  lp;
  logic [FRAME_BITS-1:0] lf;
  assign out_ready = out_valid && (wt == slow);
  assign in_valid = bv || lp;
  // Idle input shows the inverse of the last frame so no stale copy passes
  assign in_frame = lp ? lf : (bv ? bf : ~lf);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wt <= 2'h0;
      lp <= 1'b0;
      lf <= 11'h000;
    end else begin
      wt <= (out_valid && !out_ready) ? wt + 2'h1 : 2'h0;
      if (out_valid && out_ready && loop_en) begin
        lp <= 1'b1;
        lf <= out_frame ^ {10'h000, flip};
      end else if (lp && in_ready) begin
        lp <= 1'b0;
      end
    end
  end
endmodule : lrh_ring_model

//--- lrh_source.sv
// Source handshake: one frame in transit, compare on return.
// Assumes the returning frame is presented by the receive side of the node.
`timescale 1ns/10ps
module lrh_source
  import lrh_pkg::*;
(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // Frame to send and ring output
  lrh_ring_if.dst                    req,
  lrh_ring_if.src                    ring,
  // Returned frame
  input  wire logic                  ret_valid,
  input  wire logic [FRAME_BITS-1:0] ret_frame,
  // Result
  output logic                       busy,
  output logic                       done,
  output logic                       err
);
  lrh_src_state_t state;
  logic [FRAME_BITS-1:0] sent;
  wire take = req.valid && ring.ready && state == LRH_SRC_IDLE;
  wire back = ret_valid && state == LRH_SRC_WAIT;

  assign req.ready  = ring.ready && state == LRH_SRC_IDLE;   // [R9]
  assign ring.valid = req.valid && state == LRH_SRC_IDLE;
  assign ring.frame = req.frame;
  assign busy       = state == LRH_SRC_WAIT;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= LRH_SRC_IDLE;
      sent  <= '0;
      done  <= 1'b0;
      err   <= 1'b0;
    end else begin
      done <= back;
      if (back) err <= ret_frame != sent;                    // [R11]
      if (take) begin
        sent  <= req.frame;
        state <= LRH_SRC_WAIT;                               // [R9]
      end else if (back) begin
        state <= LRH_SRC_IDLE;
      end
    end
  end
endmodule : lrh_source
